/* File: src/pec_engine.sv */
// Power, current, charge and energy calculation engine with conversion sequencer
`timescale 1ns/100ps
`include "pec_consts.svh"
module pec_engine #(
  parameter int DW = 20,
  parameter int CW = 15,
  parameter int PW = 24,
  parameter int AW = 40
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Configuration from the register file
  input wire logic runEn,
  input wire logic trigger,
  input wire logic [2:0] chanEn,
  input wire logic [2:0] avgCode,
  input wire logic [CW-1:0] shuntCal,
  input wire logic clearAccum,
  // ADC multiplexer handshake
  output logic adcStart_q,
  output logic [1:0] adcChan_q,
  input wire logic adcDone,
  input wire logic [DW-1:0] adcData,
  // Output register loads
  output logic signed [DW-1:0] curOut_q,
  output logic [DW-1:0] busOut_q,
  output logic signed [DW-1:0] tempOut_q,
  output logic signed [PW-1:0] powOut_q,
  output logic signed [AW-1:0] chargeOut_q,
  output logic signed [AW-1:0] energyOut_q,
  output logic resultLoad_q,
  output logic accumValid_q
);
  localparam int SW = DW + 10;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Lowest enabled channel at or above start, none gives the spare code
  function automatic logic [1:0] pecFindChan(input logic [1:0] start, input logic [2:0] en);
    logic [1:0] r;
    r = `PEC_CH_NONE;
    for (int i = 2; i >= 0; i--) begin
      if (i >= int'(start) && en[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : pecFindChan

  // Averaging count code to shift: 1,4,16,64,128,256,512,1024
  function automatic logic [3:0] pecAvgShift(input logic [2:0] code);
    case (code)
      3'h0: pecAvgShift = 4'h0;
      3'h1: pecAvgShift = 4'h2;
      3'h2: pecAvgShift = 4'h4;
      3'h3: pecAvgShift = 4'h6;
      3'h4: pecAvgShift = 4'h7;
      3'h5: pecAvgShift = 4'h8;
      3'h6: pecAvgShift = 4'h9;
      default: pecAvgShift = 4'hA;
    endcase
  endfunction : pecAvgShift

  // Power from a current and a bus value, used per sample and after averaging
  function automatic logic signed [PW-1:0] pecPower(input logic signed [DW-1:0] cur, input logic [DW-1:0] bus);
    logic signed [2*DW:0] p;
    p = cur * $signed({1'b0, bus});
    return PW'(p >>> `PEC_POW_SHIFT);
  endfunction : pecPower

  // ----------------------------------------
  // Combinational calculation
  // ----------------------------------------
  pec_pkg::pec_seq_e state_q;
  logic [1:0] nextChan;
  logic [1:0] firstChan;
  logic wrap;
  logic calZero;
  logic avgOn;
  logic [9:0] avgCnt_q;
  logic avgLast;
  logic loadPend_q;
  logic signed [DW-1:0] lastCur_q;
  logic signed [DW+CW:0] curProd;
  logic signed [DW-1:0] curCalc;
  logic signed [PW-1:0] powCalc;
  logic signed [SW-1:0] sumCur_q;
  logic signed [SW-1:0] sumBus_q;
  logic signed [SW-1:0] sumTemp_q;
  logic [3:0] avgSh;
  logic signed [DW-1:0] avgCur;
  logic [DW-1:0] avgBus;
  logic signed [DW-1:0] avgTemp;
  logic sampShunt;
  logic sampBus;
  logic sampTemp;

  // Channel walk and averaging status
  assign firstChan = pecFindChan(2'h0, chanEn);
  assign nextChan = pecFindChan(2'(adcChan_q + 2'h1), chanEn);
  assign wrap = state_q == pec_pkg::SEQ_CONV && adcDone && nextChan == `PEC_CH_NONE;
  assign calZero = shuntCal == '0;
  assign avgOn = avgCode != 3'h0;
  assign avgSh = pecAvgShift(avgCode);
  assign avgLast = avgCnt_q == 10'((`PEC_AVG_MAX >> (10 - int'(avgSh))) - 1);
  assign sampShunt = state_q == pec_pkg::SEQ_CONV && adcDone && adcChan_q == `PEC_CH_SHUNT;
  assign sampBus = state_q == pec_pkg::SEQ_CONV && adcDone && adcChan_q == `PEC_CH_BUS;
  assign sampTemp = state_q == pec_pkg::SEQ_CONV && adcDone && adcChan_q == `PEC_CH_TEMP;

  // Current from shunt sample, power from latest current and new bus sample
  assign curProd = $signed(adcData) * $signed({1'b0, shuntCal});
  assign curCalc = DW'(curProd >>> `PEC_CUR_SHIFT);
  assign powCalc = pecPower(lastCur_q, adcData);

  // Averages as shifts, every count is a power of two
  assign avgCur = DW'(sumCur_q >>> avgSh);
  assign avgBus = DW'(sumBus_q >>> avgSh);
  assign avgTemp = DW'(sumTemp_q >>> avgSh);

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  // Starts the next channel in the cycle the last ends, so math never stalls it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= pec_pkg::SEQ_IDLE;
      adcStart_q <= `PEC_ZERO;
      adcChan_q <= `PEC_CH_NONE;
    end else begin
      adcStart_q <= 1'b0;
      case (state_q)
        pec_pkg::SEQ_IDLE: begin
          if ((runEn || trigger) && firstChan != `PEC_CH_NONE) begin
            state_q <= pec_pkg::SEQ_CONV;
            adcStart_q <= 1'b1;
            adcChan_q <= firstChan;
          end
        end
        pec_pkg::SEQ_CONV: begin
          if (adcDone) begin
            if (nextChan != `PEC_CH_NONE) begin
              adcStart_q <= 1'b1;
              adcChan_q <= nextChan;
            end else if (firstChan == `PEC_CH_NONE || (!runEn && (!avgOn || avgLast))) begin
              state_q <= pec_pkg::SEQ_IDLE;
            end else begin
              adcStart_q <= 1'b1;
              adcChan_q <= firstChan;
            end
          end
        end
        default: state_q <= pec_pkg::SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Averaging accumulators
  // ----------------------------------------
  // Count of completed cycles and pending load of the averaged set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avgCnt_q <= '0;
      loadPend_q <= `PEC_ZERO;
    end else begin
      loadPend_q <= wrap && avgOn && avgLast;
      if (wrap) begin
        avgCnt_q <= (avgLast || !avgOn) ? '0 : avgCnt_q + 10'h1;
      end
    end
  end

  // Sums clear on the load cycle; the ADC cannot finish in that cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sumCur_q <= '0;
      sumBus_q <= '0;
      sumTemp_q <= '0;
    end else if (loadPend_q || !avgOn) begin
      sumCur_q <= '0;
      sumBus_q <= '0;
      sumTemp_q <= '0;
    end else begin
      if (sampShunt) sumCur_q <= sumCur_q + SW'(curCalc);
      if (sampBus) sumBus_q <= sumBus_q + SW'({1'b0, adcData});
      if (sampTemp) sumTemp_q <= sumTemp_q + SW'($signed(adcData));
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Direct loads without averaging, averaged set after the last cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      curOut_q <= '0;
      busOut_q <= '0;
      tempOut_q <= '0;
      powOut_q <= '0;
      lastCur_q <= '0;
      resultLoad_q <= `PEC_ZERO;
    end else begin
      resultLoad_q <= (wrap && !avgOn) || loadPend_q;
      if (sampShunt) lastCur_q <= curCalc;
      if (loadPend_q) begin
        curOut_q <= avgCur;
        busOut_q <= avgBus;
        tempOut_q <= avgTemp;
        powOut_q <= calZero ? '0 : pecPower(avgCur, avgBus);
      end else begin
        if (sampShunt && !avgOn) curOut_q <= curCalc;
        if (sampBus && !avgOn) busOut_q <= adcData;
        if (sampTemp && !avgOn) tempOut_q <= $signed(adcData);
        if (calZero) begin
          powOut_q <= '0;
        end else if (sampBus && !avgOn) begin
          powOut_q <= powCalc;
        end
      end
    end
  end

  // Charge grows every shunt conversion and energy every bus conversion, averaging bypassed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chargeOut_q <= '0;
      energyOut_q <= '0;
      accumValid_q <= `PEC_ZERO;
    end else begin
      accumValid_q <= runEn;
      if (calZero || clearAccum) begin
        chargeOut_q <= '0;
        energyOut_q <= '0;
      end else begin
        if (sampShunt) chargeOut_q <= chargeOut_q + AW'(curCalc);
        if (sampBus) energyOut_q <= energyOut_q + AW'(powCalc);
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  start_chan_a: assert property (adcStart_q |-> adcChan_q != `PEC_CH_NONE)
    else $error("Conversion started on no channel");
  one_conv_a: assert property ((state_q == pec_pkg::SEQ_CONV && !adcDone) |=> !adcStart_q)
    else $error("Second conversion started while one is running");
  no_gap_a: assert property ((wrap && runEn && firstChan != `PEC_CH_NONE) |=> adcStart_q)
    else $error("Continuous cycle did not restart at once");
  direct_cur_a: assert property ((sampShunt && !avgOn) |=> curOut_q == $past(curCalc))
    else $error("Current not loaded directly");
  power_bus_a: assert property ((sampBus && !avgOn && !calZero && !loadPend_q) |=> powOut_q == $past(powCalc))
    else $error("Power not updated after bus sample");
  cal_zero_a: assert property (calZero |=> powOut_q == '0 && chargeOut_q == '0 && energyOut_q == '0)
    else $error("Zero calibration left nonzero results");
  temp_sum_a: assert property ((sampTemp && avgOn && !loadPend_q) |=> sumTemp_q == $past(sumTemp_q) + SW'($signed($past(adcData))))
    else $error("Temperature sample not accumulated");
  avg_load_a: assert property ((wrap && avgOn && avgLast) |=> ##1 resultLoad_q && curOut_q == $past(avgCur))
    else $error("Averaged set not loaded");
  charge_acc_a: assert property ((sampShunt && !calZero && !clearAccum) |=> chargeOut_q == $past(chargeOut_q) + AW'($past(curCalc)))
    else $error("Charge did not add current");
  avg_bound_a: assert property (avgCnt_q <= 10'((`PEC_AVG_MAX >> (10 - int'(avgSh))) - 1))
    else $error("Averaging count exceeded");
  valid_mode_a: assert property (1'b1 |=> accumValid_q == $past(runEn))
    else $error("Accumulator validity wrong for mode");

  shunt_seen_c: cover property (sampShunt ##[1:50] sampBus);
  avg_done_c: cover property (loadPend_q ##1 resultLoad_q);
  restart_c: cover property (wrap ##1 adcStart_q);
endmodule : pec_engine

/* File: src/pec_consts.svh */
// Constants of the power and energy calculation engine
// Contract
// - Each shunt conversion yields a new current and updates charge.
// - Each bus conversion yields power and energy from latest current and bus value.
// - A zero shunt calibration forces power, energy and charge to zero.
// - With one-sample averaging results load straight to outputs after each conversion.
// - With averaging, each new sample adds into its own accumulator until count reached.
// - After the last averaged set, average current and voltage, compute power, load all.
// - Energy and charge accumulate every bus and shunt conversion, never averaged.
// - Calculations run beside conversion and add no time to the cycle.
// - One ADC is time-shared between shunt, bus and temperature channels.
// - One averaging count, 1 to 1024, applies to all enabled channels.
// - Enabled channels convert one after another in sequence.
// - In triggered mode energy and charge are flagged invalid.
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH
// ----------------------------------------
// Channel codes of the input multiplexer
// ----------------------------------------
`define PEC_CH_SHUNT 2'h0
`define PEC_CH_BUS 2'h1
`define PEC_CH_TEMP 2'h2
`define PEC_CH_NONE 2'h3
// ----------------------------------------
// Scaling and reset values
// ----------------------------------------
`define PEC_CUR_SHIFT 11
`define PEC_POW_SHIFT 16
`define PEC_AVG_MAX 1024
`define PEC_ZERO 1'b0
`endif

/* File: src/pec_pkg.sv */
// Types shared by the power and energy calculation engine
package pec_pkg;
  // Conversion sequencer states
  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_CONV
  } pec_seq_e;
endpackage : pec_pkg

/* File: testbench/pec_adc_model.sv */
// Behavioural ADC with input multiplexer facing the calculation engine
`timescale 1ns/100ps
module pec_adc_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Engine handshake
  input wire logic adcStart,
  input wire logic [1:0] adcChan,
  output logic adcDone,
  output logic [19:0] adcData,
  // Analog values and latency in cycles, at least 2
  input wire logic [19:0] shuntVal,
  input wire logic [19:0] busVal,
  input wire logic [19:0] tempVal,
  input wire logic [3:0] delay
);
  logic [3:0] cnt;
  logic [1:0] chan;
  // One conversion per start; data shows inverse of last value outside done
  always @(negedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      adcDone <= 1'b0;
      adcData <= 20'hFFFFF;
    end else if (adcStart) begin
      cnt <= delay;
      chan <= adcChan;
      adcDone <= 1'b0;
      adcData <= ~adcData;
    end else if (cnt == 4'h1) begin
      cnt <= 4'h0;
      adcDone <= 1'b1;
      // Single converter, multiplexed by channel code
      adcData <= (chan == 2'h0) ? shuntVal : (chan == 2'h1) ? busVal : tempVal;
    end else begin
      cnt <= (cnt > 4'h1) ? cnt - 4'h1 : cnt;
      adcDone <= 1'b0;
      adcData <= ~adcData;
    end
  end
endmodule : pec_adc_model

/* File: testbench/testbench.sv */
// Self-checking bench of the calculation engine
`timescale 1ns/100ps
module testbench;
  logic clock, rst, runEn, trigger, clearAccum, adcStart, adcDone, resultLoad, accumValid;
  logic [2:0] chanEn, avgCode;
  logic [14:0] shuntCal;
  logic [1:0] adcChan;
  logic [19:0] adcData, busOut;
  logic signed [19:0] curOut, tempOut;
  logic signed [23:0] powOut;
  logic signed [39:0] chargeOut, energyOut;
  logic [3:0] delay;
  logic [1:0] chanSeq [$];
  int n_mismatch = 0;
  int compares = 0;
  // Fixed inputs: current 800 at cal 0x800, power 1600 at this bus value
  localparam logic [19:0] SHUNT = 20'h00320;
  localparam logic [19:0] BUS = 20'h20000;
  localparam logic [19:0] TEMP = 20'h00123;
  pec_engine DUT (.clock(clock), .rst(rst), .runEn(runEn), .trigger(trigger), .chanEn(chanEn),
    .avgCode(avgCode), .shuntCal(shuntCal), .clearAccum(clearAccum), .adcStart_q(adcStart),
    .adcChan_q(adcChan), .adcDone(adcDone), .adcData(adcData), .curOut_q(curOut), .busOut_q(busOut),
    .tempOut_q(tempOut), .powOut_q(powOut), .chargeOut_q(chargeOut), .energyOut_q(energyOut),
    .resultLoad_q(resultLoad), .accumValid_q(accumValid));
  pec_adc_model adc (.clock(clock), .rst(rst), .adcStart(adcStart), .adcChan(adcChan), .adcDone(adcDone),
    .adcData(adcData), .shuntVal(SHUNT), .busVal(BUS), .tempVal(TEMP), .delay(delay));
  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Record channel of every conversion start, sampled mid-cycle where settled
  always @(negedge clock) begin
    if (adcStart === 1'b1) chanSeq.push_back(adcChan);
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for the next result load; a hang ends the run
  task automatic wait_load();
    int i;
    i = 0;
    @(negedge clock);
    while (resultLoad !== 1'b1 && i < 7000) begin
      @(negedge clock);
      i++;
    end
    if (i >= 7000) begin
      chk(64'h0, 64'h1);
      end_sim();
    end
  endtask : wait_load
  // Short reset between tests so accumulators start from zero
  task automatic setup(input logic [2:0] ch, input logic [2:0] avg, input logic [14:0] cal);
    @(negedge clock);
    rst = 1'b1;
    runEn = 1'b0;
    chanEn = ch;
    avgCode = avg;
    shuntCal = cal;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    chanSeq.delete();
  endtask : setup
  task automatic test_single();
    setup(3'h7, 3'h0, 15'h0800);
    runEn = 1'b1;
    wait_load();
    chk(curOut, 64'd800);
    chk(busOut, BUS);
    chk(tempOut, TEMP);
    chk(powOut, 64'd1600);
    chk(chargeOut, 64'd800);
    chk(energyOut, 64'd1600);
    chk(accumValid, 64'h1);
    wait_load();
    chk(chargeOut, 64'd1600);
    chk(energyOut, 64'd3200);
    chk(chanSeq[0], 64'h0);
    chk(chanSeq[1], 64'h1);
    chk(chanSeq[2], 64'h2);
    chk(chanSeq[3], 64'h0);
    clearAccum = 1'b1;
    repeat (2) @(negedge clock);
    chk(chargeOut, 64'h0);
    clearAccum = 1'b0;
    $display("test_single done");
  endtask : test_single
  task automatic test_avg();
    setup(3'h3, 3'h1, 15'h0800);
    trigger = 1'b1;
    @(negedge clock);
    trigger = 1'b0;
    wait_load();
    chk(curOut, 64'd800);
    chk(powOut, 64'd1600);
    chk(chargeOut, 64'd3200);
    chk(energyOut, 64'd6400);
    chk(accumValid, 64'h0);
    repeat (30) @(negedge clock);
    chk(chanSeq.size(), 64'd8);
    $display("test_avg done");
  endtask : test_avg
  task automatic test_zero();
    setup(3'h3, 3'h0, 15'h0000);
    runEn = 1'b1;
    wait_load();
    chk(powOut, 64'h0);
    chk(chargeOut, 64'h0);
    chk(energyOut, 64'h0);
    chk(busOut, BUS);
    $display("test_zero done");
  endtask : test_zero
  // Bus channel off, slow converter
  task automatic test_skip();
    setup(3'h5, 3'h0, 15'h0800);
    delay = 4'h7;
    runEn = 1'b1;
    wait_load();
    chk(chanSeq[0], 64'h0);
    chk(chanSeq[1], 64'h2);
    chk(tempOut, TEMP);
    chk(chargeOut, 64'd800);
    chk(energyOut, 64'h0);
    delay = 4'h2;
    $display("test_skip done");
  endtask : test_skip
  // Longest averaging in triggered mode, temperature sums included
  task automatic test_avg_max();
    setup(3'h5, 3'h7, 15'h0800);
    trigger = 1'b1;
    @(negedge clock);
    trigger = 1'b0;
    wait_load();
    chk(curOut, 64'd800);
    chk(tempOut, TEMP);
    chk(powOut, 64'h0);
    chk(chargeOut, 64'd819200);
    chk(energyOut, 64'h0);
    chk(chanSeq.size(), 64'd2048);
    $display("test_avg_max done");
  endtask : test_avg_max
  // Main sequence
  initial begin
    rst = 1'b1;
    runEn = 1'b0;
    trigger = 1'b0;
    clearAccum = 1'b0;
    chanEn = 3'h0;
    avgCode = 3'h0;
    shuntCal = 15'h0000;
    delay = 4'h2;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    test_single();
    test_avg();
    test_zero();
    test_skip();
    test_avg_max();
    end_sim();
  end
endmodule : testbench
